// ### logic/cmfs_pkg.sv
// Package of constants, register map and carrier types for the fault supervisor
package cmfs_pkg;
    // ****************************************************************
    // Sizes and timing
    // ****************************************************************
    localparam int NUM_CH = 18;
    localparam int CLK_HZ = 125000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [11:0] RED_FAIL_ON_MS = 12'd1350;
    localparam logic [11:0] RED_FAIL_OFF_MS = 12'd850;
    localparam logic [11:0] WDOG_ON_MS = 12'd1000;
    localparam logic [11:0] WDOG_OFF_MS = 12'd1500;
    localparam logic [11:0] BROWN_ON_MS = 12'd400;
    localparam logic [11:0] BROWN_OFF_MS = 12'd80;
    localparam int FLASH_HALF_MS = 250;
    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_FAULT_CH = 8'h0c;
    localparam logic [7:0] OFS_LIVE = 8'h10;
    localparam logic [7:0] OFS_RF_HOLD = 8'h14;
    localparam logic [7:0] OFS_RF_EN = 8'h18;
    // Control bits
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_RFMON_BIT = 1;
    // Status bit positions, shared by the mask
    localparam int ST_AC = 0;
    localparam int ST_WDOG = 1;
    localparam int ST_CONFLICT = 2;
    localparam int ST_REDFAIL = 3;
    localparam int ST_CARD = 4;
    localparam int ST_W = 5;
    localparam logic [ST_W-1:0] MASK_RESET = 5'h00;
    localparam logic [NUM_CH-1:0] RF_EN_RESET = 18'h3ffff;

    // Option straps
    typedef struct packed {
        logic red_fail_long;
        logic wdog_short;
        logic brown_long;
        logic wdog_latch;
        logic relay_pol_inv;
    } cmfs_opt_t;

    // Front panel indicators
    typedef struct packed {
        logic ac_power;
        logic dc_fail;
        logic watchdog_error;
        logic conflict;
        logic red_fail;
        logic dual_ind;
        logic clearance;
        logic card_absent;
        logic diag_fail;
    } cmfs_led_t;
endpackage

// ### logic/cmfs_supervisor.sv
// Fault supervisor: option timing, fault latching, indicators and APB registers
// What this block does
// - Eighteen channels are watched, each with green, yellow and red inputs.
// - A missing programming card forces fault mode until it is back and a reset follows.
// - On a fault the guilty channels and every channel's state are frozen until reset.
// - Nine status lamps plus red, yellow and green lamps per channel are driven.
// - The red fail time is 1350 ms with its switch on and 850 ms with it off.
// - The watchdog time is 1.0 s with its switch on and 1.5 s with it off.
// - The brown-out option selects 400 ms or 80 ms qualification time.
// - Without watchdog latch, a watchdog fault clears after a qualified brown-out.
// - With watchdog latch, a watchdog fault clears only on a reset command.
// - A polarity jumper selects whether high or low relay common means active.
// - Fault mode holds until a front panel, remote or CTRL register reset.
// - Low AC line triggers the monitor and flashes the AC lamp at 2 Hz, 50% duty.
`timescale 1ns/1ps
module cmfs_supervisor #(
    parameter int NUM_CH = cmfs_pkg::NUM_CH,
    parameter int TICK_CYCLES = cmfs_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_CH-1:0] field_green,
    input wire logic [NUM_CH-1:0] field_yellow,
    input wire logic [NUM_CH-1:0] field_red,
    input wire logic [NUM_CH-1:0] conflict_in,
    input wire logic program_card_absent,
    input wire logic watchdog_pulse,
    input wire logic ac_line_low,
    input wire logic dc_fail_in,
    input wire logic diag_fail_in,
    input wire logic dual_fault_in,
    input wire logic clearance_fault_in,
    input wire logic output_relay_common,
    input wire logic panel_reset,
    input wire logic remote_reset,
    input wire cmfs_pkg::cmfs_opt_t opt,
    output cmfs_pkg::cmfs_led_t status_led,
    output logic [NUM_CH-1:0] ch_led_green,
    output logic [NUM_CH-1:0] ch_led_yellow,
    output logic [NUM_CH-1:0] ch_led_red,
    output logic relay_common_active,
    output logic fault_mode,
    output logic irq
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int SW = 4 * NUM_CH + 10;
    logic [SW-1:0] s1_r, s2_r;
    logic [SW-1:0] raw_in;
    logic [NUM_CH-1:0] g_s, y_s, r_s, c_s;
    logic card_s, wd_s, acl_s, dc_s, dg_s, du_s, cl_s, rc_s, pr_s, rr_s;
    cmfs_pkg::cmfs_opt_t opt_s;

    assign raw_in = {field_green, field_yellow, field_red, conflict_in,
        program_card_absent, watchdog_pulse, ac_line_low, dc_fail_in, diag_fail_in,
        dual_fault_in, clearance_fault_in, output_relay_common, panel_reset, remote_reset};

    // Two stages: every non-APB input is foreign to pclk
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r <= '0;
            s2_r <= '0;
        end
        else
        begin
            s1_r <= raw_in;
            s2_r <= s1_r;
        end
    end

    // Options in a separate pair keeps the struct intact
    cmfs_pkg::cmfs_opt_t o1_r, o2_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            o1_r <= '0;
            o2_r <= '0;
        end
        else
        begin
            o1_r <= opt;
            o2_r <= o1_r;
        end
    end
    assign opt_s = o2_r;
    assign {g_s, y_s, r_s, c_s} = s2_r[SW-1 -: 4 * NUM_CH];
    assign {card_s, wd_s, acl_s, dc_s, dg_s, du_s, cl_s, rc_s, pr_s, rr_s} = s2_r[9:0];

    // ****************************************************************
    // Millisecond tick and 2 Hz flasher
    // ****************************************************************
    logic [16:0] div_r, div_nxt;
    logic [7:0] fl_cnt_r, fl_cnt_nxt;
    logic flash_r, flash_nxt;
    logic tick;

    // Tick from a divider rather than a second clock
    always_comb
    begin
        tick = (div_r == 17'(TICK_CYCLES - 1));
        div_nxt = tick ? 17'h0 : div_r + 17'h1;
        fl_cnt_nxt = fl_cnt_r;
        flash_nxt = flash_r;
        if (tick)
        begin
            if (fl_cnt_r == 8'(cmfs_pkg::FLASH_HALF_MS - 1))
            begin
                fl_cnt_nxt = 8'h0;
                flash_nxt = ~flash_r; // 250 ms each half
            end
            else
            begin
                fl_cnt_nxt = fl_cnt_r + 8'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_r <= 17'h0;
            fl_cnt_r <= 8'h0;
            flash_r <= 1'b0;
        end
        else
        begin
            div_r <= div_nxt;
            fl_cnt_r <= fl_cnt_nxt;
            flash_r <= flash_nxt;
        end
    end

    // ****************************************************************
    // Fault timers and latches
    // ****************************************************************
    logic [11:0] rf_lim, wd_lim, bo_lim;
    logic [NUM_CH-1:0] no_ind;
    logic [11:0] rf_cnt_r [NUM_CH];
    logic [11:0] rf_cnt_nxt [NUM_CH];
    logic [11:0] wd_cnt_r, wd_cnt_nxt, bo_cnt_r, bo_cnt_nxt;
    logic wd_prev_r, wd_prev_nxt;
    logic brown_r, brown_nxt;
    logic wd_flt_r, wd_flt_nxt, cf_flt_r, cf_flt_nxt, rf_flt_r, rf_flt_nxt;
    logic card_flt_r, card_flt_nxt, oth_flt_r, oth_flt_nxt;
    logic [NUM_CH-1:0] fch_r, fch_nxt, hg_r, hg_nxt, hy_r, hy_nxt, hr_r, hr_nxt;
    logic [NUM_CH-1:0] rf_hit;
    logic frozen_r, frozen_nxt;
    logic do_reset, sw_reset, rfmon_r, rfmon_nxt;
    logic [NUM_CH-1:0] rf_en_r, rf_en_nxt;

    assign rf_lim = opt_s.red_fail_long ? cmfs_pkg::RED_FAIL_ON_MS : cmfs_pkg::RED_FAIL_OFF_MS;
    assign wd_lim = opt_s.wdog_short ? cmfs_pkg::WDOG_ON_MS : cmfs_pkg::WDOG_OFF_MS;
    assign bo_lim = opt_s.brown_long ? cmfs_pkg::BROWN_ON_MS : cmfs_pkg::BROWN_OFF_MS;
    assign relay_common_active = opt_s.relay_pol_inv ? ~rc_s : rc_s;
    assign no_ind = ~(g_s | y_s | r_s);
    assign do_reset = pr_s | rr_s | sw_reset;

    // Red fail timers, one per channel
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            rf_hit[i] = 1'b0;
            rf_cnt_nxt[i] = rf_cnt_r[i];
            if (!no_ind[i] || !rf_en_r[i] || !rfmon_r || relay_common_active)
                rf_cnt_nxt[i] = 12'h0;
            else if (tick)
            begin
                if (rf_cnt_r[i] >= rf_lim - 12'h1)
                    rf_hit[i] = 1'b1;
                else
                    rf_cnt_nxt[i] = rf_cnt_r[i] + 12'h1;
            end
        end
    end

    // Watchdog, brown-out and latch logic
    always_comb
    begin
        wd_prev_nxt = wd_s;
        wd_cnt_nxt = wd_cnt_r;
        bo_cnt_nxt = bo_cnt_r;
        brown_nxt = brown_r;
        wd_flt_nxt = wd_flt_r;
        cf_flt_nxt = cf_flt_r;
        rf_flt_nxt = rf_flt_r;
        card_flt_nxt = card_flt_r;
        oth_flt_nxt = oth_flt_r;
        fch_nxt = fch_r;
        hg_nxt = frozen_r ? hg_r : g_s;
        hy_nxt = frozen_r ? hy_r : y_s;
        hr_nxt = frozen_r ? hr_r : r_s;
        frozen_nxt = frozen_r;
        if (wd_s != wd_prev_r || brown_r)
            wd_cnt_nxt = 12'h0;
        else if (tick && wd_cnt_r < wd_lim)
            wd_cnt_nxt = wd_cnt_r + 12'h1;
        if (!acl_s)
        begin
            bo_cnt_nxt = 12'h0;
            brown_nxt = 1'b0;
        end
        else if (tick && bo_cnt_r < bo_lim)
            bo_cnt_nxt = bo_cnt_r + 12'h1;
        else if (bo_cnt_r >= bo_lim)
            brown_nxt = 1'b1;
        // Reset first so a new fault in the same cycle still latches
        if (do_reset)
        begin
            wd_flt_nxt = 1'b0;
            cf_flt_nxt = 1'b0;
            rf_flt_nxt = 1'b0;
            card_flt_nxt = 1'b0;
            oth_flt_nxt = 1'b0;
            fch_nxt = '0;
            frozen_nxt = 1'b0;
        end
        if (brown_r && !opt_s.wdog_latch)
            wd_flt_nxt = 1'b0;
        if (!frozen_r || do_reset)
        begin
            if (wd_cnt_r >= wd_lim)
                wd_flt_nxt = 1'b1;
            if (|c_s)
            begin
                cf_flt_nxt = 1'b1;
                fch_nxt = c_s;
            end
            if (|rf_hit)
            begin
                rf_flt_nxt = 1'b1;
                fch_nxt = fch_nxt | rf_hit;
            end
        end
        if (card_s)
            card_flt_nxt = 1'b1; // holds while card is out
        if (du_s || cl_s || dc_s || dg_s)
            oth_flt_nxt = 1'b1;
        if (wd_flt_nxt || cf_flt_nxt || rf_flt_nxt || card_flt_nxt || oth_flt_nxt || brown_r)
            frozen_nxt = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_CH; i++)
                rf_cnt_r[i] <= 12'h0;
            wd_cnt_r <= 12'h0;
            bo_cnt_r <= 12'h0;
            wd_prev_r <= 1'b0;
            brown_r <= 1'b0;
            wd_flt_r <= 1'b0;
            cf_flt_r <= 1'b0;
            rf_flt_r <= 1'b0;
            card_flt_r <= 1'b0;
            oth_flt_r <= 1'b0;
            fch_r <= '0;
            hg_r <= '0;
            hy_r <= '0;
            hr_r <= '0;
            frozen_r <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
                rf_cnt_r[i] <= rf_cnt_nxt[i];
            wd_cnt_r <= wd_cnt_nxt;
            bo_cnt_r <= bo_cnt_nxt;
            wd_prev_r <= wd_prev_nxt;
            brown_r <= brown_nxt;
            wd_flt_r <= wd_flt_nxt;
            cf_flt_r <= cf_flt_nxt;
            rf_flt_r <= rf_flt_nxt;
            card_flt_r <= card_flt_nxt;
            oth_flt_r <= oth_flt_nxt;
            fch_r <= fch_nxt;
            hg_r <= hg_nxt;
            hy_r <= hy_nxt;
            hr_r <= hr_nxt;
            frozen_r <= frozen_nxt;
        end
    end

    // ****************************************************************
    // Indicators
    // ****************************************************************
    cmfs_pkg::cmfs_led_t led_nxt;
    logic [NUM_CH-1:0] clg_nxt, cly_nxt, clr_nxt;

    // Lamps from flops; channel lamps show frozen state while faulted
    always_comb
    begin
        led_nxt.ac_power = brown_r ? flash_r : 1'b1;
        led_nxt.dc_fail = dc_s;
        led_nxt.watchdog_error = wd_flt_r;
        led_nxt.conflict = cf_flt_r;
        led_nxt.red_fail = rf_flt_r;
        led_nxt.dual_ind = du_s;
        led_nxt.clearance = cl_s;
        led_nxt.card_absent = card_flt_r;
        led_nxt.diag_fail = dg_s;
        clg_nxt = hg_r;
        cly_nxt = hy_r;
        clr_nxt = hr_r | (frozen_r ? fch_r : '0);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_led <= '0;
            ch_led_green <= '0;
            ch_led_yellow <= '0;
            ch_led_red <= '0;
        end
        else
        begin
            status_led <= led_nxt;
            ch_led_green <= clg_nxt;
            ch_led_yellow <= cly_nxt;
            ch_led_red <= clr_nxt;
        end
    end
    assign fault_mode = frozen_r;

    // ****************************************************************
    // APB registers and interrupt
    // ****************************************************************
    logic [cmfs_pkg::ST_W-1:0] st_r, st_nxt, mask_r, mask_nxt, ev;
    logic [31:0] rd_nxt;
    logic wr, rd;

    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite; // Setup cycle, so data stands at the access edge
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign sw_reset = wr && paddr == cmfs_pkg::OFS_CTRL && pwdata[cmfs_pkg::CTRL_RESET_BIT];
    assign ev = {card_flt_r, rf_flt_r, cf_flt_r, wd_flt_r, brown_r};
    assign irq = |(st_r & mask_r);

    // Write-one-to-clear; a new event wins over the clear
    always_comb
    begin
        st_nxt = st_r;
        mask_nxt = mask_r;
        rfmon_nxt = rfmon_r;
        rf_en_nxt = rf_en_r;
        if (wr && paddr == cmfs_pkg::OFS_STATUS)
            st_nxt = st_r & ~pwdata[cmfs_pkg::ST_W-1:0];
        st_nxt = st_nxt | ev;
        if (wr && paddr == cmfs_pkg::OFS_MASK)
            mask_nxt = pwdata[cmfs_pkg::ST_W-1:0];
        if (wr && paddr == cmfs_pkg::OFS_CTRL)
            rfmon_nxt = pwdata[cmfs_pkg::CTRL_RFMON_BIT];
        if (wr && paddr == cmfs_pkg::OFS_RF_EN)
            rf_en_nxt = pwdata[NUM_CH-1:0];
        rd_nxt = 32'h0;
        unique case (paddr)
            cmfs_pkg::OFS_CTRL: rd_nxt = {30'h0, rfmon_r, 1'b0};
            cmfs_pkg::OFS_STATUS: rd_nxt = 32'(st_r);
            cmfs_pkg::OFS_MASK: rd_nxt = 32'(mask_r);
            cmfs_pkg::OFS_FAULT_CH: rd_nxt = 32'(fch_r);
            cmfs_pkg::OFS_LIVE: rd_nxt = {31'h0, frozen_r};
            cmfs_pkg::OFS_RF_HOLD: rd_nxt = 32'(hr_r);
            cmfs_pkg::OFS_RF_EN: rd_nxt = 32'(rf_en_r);
            default: rd_nxt = 32'h0;
        endcase
        if (!rd)
            rd_nxt = prdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
            mask_r <= cmfs_pkg::MASK_RESET;
            rfmon_r <= 1'b1;
            rf_en_r <= cmfs_pkg::RF_EN_RESET;
            prdata <= 32'h0;
        end
        else
        begin
            st_r <= st_nxt;
            mask_r <= mask_nxt;
            rfmon_r <= rfmon_nxt;
            rf_en_r <= rf_en_nxt;
            prdata <= rd_nxt;
        end
    end
endmodule

// ### sim/cmfs_supervisor_monitor.sv
// Port checker for the fault supervisor
`timescale 1ns/1ps
module cmfs_supervisor_monitor #(
    parameter int NUM_CH = cmfs_pkg::NUM_CH,
    parameter int TICK_CYCLES = cmfs_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic pwrite,
    input wire logic [NUM_CH-1:0] conflict_in,
    input wire logic program_card_absent,
    input wire logic watchdog_pulse,
    input wire logic ac_line_low,
    input wire logic output_relay_common,
    input wire logic panel_reset,
    input wire logic remote_reset,
    input wire cmfs_pkg::cmfs_opt_t opt,
    input wire cmfs_pkg::cmfs_led_t status_led,
    input wire logic [NUM_CH-1:0] ch_led_green,
    input wire logic [NUM_CH-1:0] ch_led_yellow,
    input wire logic [NUM_CH-1:0] ch_led_red,
    input wire logic relay_common_active,
    input wire logic fault_mode
);
    int ac_n_r;
    int ac_n_nxt;
    int wd_n_r;
    int wd_n_nxt;
    logic wd_q_r;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles of held brown-out and of silent watchdog; margin covers the synchronisers
    always_comb
    begin
        ac_n_nxt = ac_line_low ? ac_n_r + 1 : 0;
        wd_n_nxt = (watchdog_pulse != wd_q_r) ? 0 : wd_n_r + 1;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ac_n_r <= 0;
            wd_n_r <= 0;
            wd_q_r <= 1'b0;
        end
        else
        begin
            ac_n_r <= ac_n_nxt;
            wd_n_r <= wd_n_nxt;
            wd_q_r <= watchdog_pulse;
        end
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    sequence s_quiet;
        (!panel_reset && !remote_reset && !(psel && pwrite)) [*4];
    endsequence
    property p_relay;
        ($stable(output_relay_common) && $stable(opt)) [*4]
            |-> relay_common_active == (output_relay_common ^ opt.relay_pol_inv);
    endproperty
    a_relay: assert property (p_relay) else $error("relay sense wrong");
    property p_card;
        program_card_absent [*3] |-> ##[0:3] fault_mode;
    endproperty
    a_card: assert property (p_card) else $error("no fault on card removal");
    property p_card_hold;
        program_card_absent && fault_mode |=> fault_mode;
    endproperty
    a_card_hold: assert property (p_card_hold) else $error("fault left, card out");
    property p_hold;
        s_quiet ##0 (fault_mode && status_led.conflict) |=> fault_mode && status_led.conflict;
    endproperty
    a_hold: assert property (p_hold) else $error("fault cleared with no reset");
    property p_conflict;
        (conflict_in != '0) [*3] |-> ##[0:3] (fault_mode && status_led.conflict);
    endproperty
    a_conflict: assert property (p_conflict) else $error("conflict not flagged");
    property p_frozen;
        fault_mode [*3] |-> $stable(ch_led_red) && $stable(ch_led_green)
            && $stable(ch_led_yellow);
    endproperty
    a_frozen: assert property (p_frozen) else $error("channel lamps moved in fault");
    property p_ac_on;
        (!ac_line_low && !fault_mode) [*8] |-> status_led.ac_power;
    endproperty
    a_ac_on: assert property (p_ac_on) else $error("ac lamp dark");
    property p_brown;
        ac_n_r == (opt.brown_long ? 400 : 80) * TICK_CYCLES + 8 |-> fault_mode;
    endproperty
    a_brown: assert property (p_brown) else $error("brown-out not caught");
    property p_wdog;
        wd_n_r == (opt.wdog_short ? 1000 : 1500) * TICK_CYCLES + 8
            |-> status_led.watchdog_error;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog not caught");
endmodule

bind cmfs_supervisor cmfs_supervisor_monitor #(.NUM_CH(NUM_CH), .TICK_CYCLES(TICK_CYCLES)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .pwrite(pwrite), .conflict_in(conflict_in),
    .program_card_absent(program_card_absent), .watchdog_pulse(watchdog_pulse),
    .ac_line_low(ac_line_low), .output_relay_common(output_relay_common),
    .panel_reset(panel_reset), .remote_reset(remote_reset), .opt(opt), .status_led(status_led),
    .ch_led_green(ch_led_green), .ch_led_yellow(ch_led_yellow), .ch_led_red(ch_led_red),
    .relay_common_active(relay_common_active), .fault_mode(fault_mode));

// ### sim/cmfs_field_model.sv
// Model of the controller and cabinet field lamps facing the supervisor
`timescale 1ns/1ps
module cmfs_field_model #(
    parameter int NUM_CH = 18
) (
    input wire logic pclk,
    input wire logic wd_run,
    input wire logic [NUM_CH-1:0] dark,
    output logic [NUM_CH-1:0] lamp_g,
    output logic [NUM_CH-1:0] lamp_y,
    output logic [NUM_CH-1:0] lamp_r,
    output logic wd_pulse = 1'b0
);
    // Lit channels rest on green; a dark channel shows no lamp at all
    assign lamp_g = ~dark;
    assign lamp_y = '0;
    assign lamp_r = '0;
    // Service every cycle, so a stop is seen within one cycle
    always @(posedge pclk)
    begin
        if (wd_run)
        begin
            wd_pulse <= ~wd_pulse;
        end
    end
endmodule

// ### sim/tb_cmfs_supervisor.sv
// Self-checking bench of the fault supervisor
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_cmfs_supervisor;
    localparam int TK = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdq;
    logic pready;
    logic pslverr;
    logic [17:0] fg, fy, fr, dark = 18'h0, conflict_in = 18'h0, ch_g, ch_y, ch_r;
    logic card = 1'b0, wd_run = 1'b1, wd_pulse, ac_low = 1'b0, relay_pin = 1'b0;
    logic panel_reset = 1'b0, remote_reset = 1'b0, rca, fault_mode, irq;
    logic [3:0] aux = 4'h0;
    cmfs_pkg::cmfs_opt_t opt = '0;
    cmfs_pkg::cmfs_led_t status_led;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    always #4 pclk = ~pclk;
    cmfs_supervisor #(.TICK_CYCLES(TK)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .field_green(fg), .field_yellow(fy),
        .field_red(fr), .conflict_in(conflict_in), .program_card_absent(card),
        .watchdog_pulse(wd_pulse), .ac_line_low(ac_low), .dc_fail_in(aux[0]),
        .diag_fail_in(aux[1]), .dual_fault_in(aux[2]), .clearance_fault_in(aux[3]),
        .output_relay_common(relay_pin), .panel_reset(panel_reset),
        .remote_reset(remote_reset), .opt(opt), .status_led(status_led), .ch_led_green(ch_g),
        .ch_led_yellow(ch_y), .ch_led_red(ch_r), .relay_common_active(rca),
        .fault_mode(fault_mode), .irq(irq));
    cmfs_field_model #(.NUM_CH(18)) u_field (.pclk(pclk), .wd_run(wd_run), .dark(dark),
        .lamp_g(fg), .lamp_y(fy), .lamp_r(fr), .wd_pulse(wd_pulse));
    // ****************************************************************
    // Bus and helper tasks
    // ****************************************************************
    task automatic end_of_test();
        if (err_count == 0 && checks > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rdq = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Read data is taken at the edge that finds pready high
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rdq, e)
        `CHK(pslverr, 1'b0)
    endtask
    task automatic rst(input logic remote);
        if (remote)
            remote_reset <= 1'b1;
        else
            panel_reset <= 1'b1;
        repeat (4) @(posedge pclk);
        remote_reset <= 1'b0;
        panel_reset <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    task automatic clr();
        rst(1'b0);
        bus(1'b1, cmfs_pkg::OFS_STATUS, 32'h1f);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
    endtask
    // Interrupt must be quiet just before the nominal time and up just after
    task automatic tmd(input int n);
        repeat (n - 20) @(posedge pclk);
        `CHK(irq, 1'b0)
        repeat (40) @(posedge pclk);
        `CHK(irq, 1'b1)
    endtask
    task automatic brown(input int ms);
        ac_low <= 1'b1;
        repeat (ms * TK) @(posedge pclk);
        ac_low <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
    // Hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_count++;
            end_of_test();
        end
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        int n;
        logic v;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc(cmfs_pkg::OFS_MASK, 32'h0);
        rdc(cmfs_pkg::OFS_RF_EN, 32'h3ffff);
        rdc(8'hfc, 32'h0);
        `CHK(status_led.ac_power, 1'b1)
        card <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK(irq, 1'b0)
        bus(1'b1, cmfs_pkg::OFS_MASK, 32'h1f);
        rst(1'b0);
        `CHK(fault_mode & irq & status_led.card_absent, 1'b1)
        card <= 1'b0;
        repeat (8) @(posedge pclk);
        `CHK(fault_mode, 1'b1)
        rst(1'b1);
        `CHK(fault_mode, 1'b0)
        clr();
        conflict_in <= 18'h00005;
        repeat (8) @(posedge pclk);
        conflict_in <= '0;
        dark <= 18'h00002;
        repeat (8) @(posedge pclk);
        `CHK(fault_mode & status_led.conflict, 1'b1)
        `CHK(ch_g, 18'h3ffff)
        rdc(cmfs_pkg::OFS_FAULT_CH, 32'h5);
        rst(1'b0);
        `CHK(ch_g, 18'h3fffd)
        dark <= '0;
        for (int i = 0; i < 4; i++)
        begin
            aux <= 4'h1 << i;
            repeat (6) @(posedge pclk);
            `CHK({status_led.clearance, status_led.dual_ind, status_led.diag_fail,
                status_led.dc_fail} & (4'h1 << i), 4'h1 << i)
            aux <= 4'h0;
            rst(1'b0);
        end
        for (int i = 0; i < 4; i++)
        begin
            opt.relay_pol_inv <= i[1];
            relay_pin <= i[0];
            repeat (6) @(posedge pclk);
            `CHK(rca, i[1] ^ i[0])
        end
        opt.relay_pol_inv <= 1'b0;
        relay_pin <= 1'b0;
        clr();
        dark <= 18'h00001;
        tmd(850 * TK);
        rdc(cmfs_pkg::OFS_FAULT_CH, 32'h1);
        `CHK(ch_r, 18'h00001)
        dark <= '0;
        clr();
        opt.red_fail_long <= 1'b1;
        dark <= 18'h00001;
        tmd(1350 * TK);
        dark <= '0;
        clr();
        opt.wdog_short <= 1'b1;
        wd_run <= 1'b0;
        tmd(1000 * TK);
        wd_run <= 1'b1;
        clr();
        opt.wdog_short <= 1'b0;
        wd_run <= 1'b0;
        tmd(1500 * TK);
        wd_run <= 1'b1;
        opt.wdog_latch <= 1'b1;
        brown(100);
        `CHK(status_led.watchdog_error, 1'b1)
        bus(1'b1, cmfs_pkg::OFS_CTRL, 32'h3);
        repeat (4) @(posedge pclk);
        `CHK(status_led.watchdog_error, 1'b0)
        opt.wdog_latch <= 1'b0;
        clr();
        wd_run <= 1'b0;
        tmd(1500 * TK);
        wd_run <= 1'b1;
        brown(100);
        `CHK(status_led.watchdog_error, 1'b0)
        clr();
        bus(1'b1, cmfs_pkg::OFS_MASK, 32'h01);
        ac_low <= 1'b1;
        tmd(80 * TK);
        ac_low <= 1'b0;
        clr();
        opt.brown_long <= 1'b1;
        ac_low <= 1'b1;
        tmd(400 * TK);
        n = 0;
        v = status_led.ac_power;
        repeat (1100)
        begin
            @(posedge pclk);
            n += (status_led.ac_power !== v);
            v = status_led.ac_power;
        end
        `CHK(n == 1 || n == 2, 1'b1)
        ac_low <= 1'b0;
        end_of_test();
    end
endmodule
